// >>> rtl/pcpd_power_down.v
// pcpd_power_down.v: sleep-pin controlled hold of a user logic slice
// assumes one 200 MHz clock; user pins arrive from outside and are synchronised
// the held logic here is a parameterised register bank standing in for the array
// when the option is enabled the sleep pin reaches no array logic at all
`timescale 1ns/1ps
`include "pcpd_defines.vh"
module pcpd_power_down #(
  parameter WIDTH      = 8,
  parameter SLEEP_EN   = 1,
  parameter WAKE_CYCLES = `PCPD_WAKE_CYCLES
) (
  input  wire             mclk_in,
  input  wire             rst_in,
  input  wire             sleep_request_pin_in,
  input  wire [WIDTH-1:0] pin_data_in,
  input  wire [WIDTH-1:0] pin_oe_n_in,
  input  wire             pin_load_in,
  input  wire             feedback_sel_in,
  output wire [WIDTH-1:0] pin_data_out,
  output wire [WIDTH-1:0] pin_oe_n_out,
  output wire [WIDTH-1:0] pin_keep_out,
  output wire [WIDTH-1:0] feedback_out,
  output wire             sleep_pin_as_io_out,
  output wire             hold_out,
  output wire             wake_busy_out
);

  // ************************************************************
  // state codes
  // ************************************************************
  localparam ST_RUN  = 2'b00;
  localparam ST_HOLD = 2'b01;
  localparam ST_WAKE = 2'b10;

  // ************************************************************
  // synchronise sleep pin and user pins
  // ************************************************************
  wire             sleep_lvl;
  wire [WIDTH-1:0] data_s;
  wire [WIDTH-1:0] drv_s;
  wire             load_s;
  wire             fsel_s;

  pcpd_sync u_sleep_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .async_in  (sleep_request_pin_in),
    .level_out (sleep_lvl)
  );

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      pcpd_sync u_d (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .async_in  (pin_data_in[g]),
        .level_out (data_s[g])
      );
      // synchronised as drive-high so the synchroniser's reset leaves the pin released
      pcpd_sync u_oe (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .async_in  (~pin_oe_n_in[g]),
        .level_out (drv_s[g])
      );
    end
  endgenerate

  pcpd_sync u_load (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .async_in  (pin_load_in),
    .level_out (load_s)
  );

  pcpd_sync u_fsel (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .async_in  (feedback_sel_in),
    .level_out (fsel_s)
  );

  // ************************************************************
  // sleep qualification
  // ************************************************************
  // enable is a build-time parameter only, no software path
  wire sleep_req = (SLEEP_EN != 0) & sleep_lvl;

  // when disabled the pin is a plain io; when enabled it never reaches the array
  assign sleep_pin_as_io_out = (SLEEP_EN == 0);

  // ************************************************************
  // sequencer
  // ************************************************************
  // a zero ramp would wrap the counter, so it counts as one cycle
  localparam WAKE_EFF  = (WAKE_CYCLES < 1) ? 1 : WAKE_CYCLES;
  localparam [31:0] WAKE_M1 = WAKE_EFF - 1;
  // last ramp count and step, cut to the counter width on purpose
  localparam [`PCPD_CNT_W-1:0] WAKE_LAST = WAKE_M1[`PCPD_CNT_W-1:0];
  localparam [`PCPD_CNT_W-1:0] CNT_ONE   = {{(`PCPD_CNT_W-1){1'b0}}, 1'b1};

  reg [1:0]            state_ff;
  reg [1:0]            nxt_state;
  reg [`PCPD_CNT_W-1:0] cnt_ff;
  reg [`PCPD_CNT_W-1:0] nxt_cnt;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (sleep_req) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!sleep_req) begin
          nxt_state = ST_WAKE;
          nxt_cnt   = {`PCPD_CNT_W{1'b0}};
        end
      end
      ST_WAKE: begin
        // the ramp is informational: inputs are accepted from its first cycle
        if (sleep_req) begin
          nxt_state = ST_HOLD;
        end else if (cnt_ff == WAKE_LAST) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= ST_RUN;
      cnt_ff   <= {`PCPD_CNT_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // sleep and pins pass equal-depth synchronisers, so a pin changed after the
  // sleep rise arrives behind it; one changed in the same cycle may still land
  // hold starts the same cycle sleep is seen so no further input is taken
  wire hold = (state_ff == ST_HOLD) | sleep_req;
  // inputs are accepted again from the first wake cycle, long before 1 us
  wire accept = ~hold;

  // ************************************************************
  // held user logic, one pin macrocell slice per bit
  // ************************************************************
  wire [WIDTH-1:0] data_q;
  wire [WIDTH-1:0] oe_n_q;
  wire [WIDTH-1:0] keep_q;
  wire [WIDTH-1:0] fb_q;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_cell
      reg data_ff;
      reg oe_n_ff;
      reg keep_ff;
      reg fb_ff;
      reg nxt_data;
      reg nxt_oe_n;
      reg nxt_keep;
      reg nxt_fb;

      // in hold every next value is the held one, high-z enables included
      always @* begin
        nxt_data = data_ff;
        nxt_oe_n = oe_n_ff;
        nxt_keep = keep_ff;
        nxt_fb   = fb_ff;
        if (accept) begin
          // resumes from whatever was held; nothing cleared on wake
          if (load_s) begin
            nxt_data = data_s[g];
          end
          // enable arrives as drive-high, so a fresh reset never drives the pin
          nxt_oe_n = ~drv_s[g];
          nxt_keep = data_s[g];
          // buried feedback of the pin macrocell stays usable
          nxt_fb   = fsel_s ? data_ff : ~data_ff;
        end
      end

      always @(posedge mclk_in) begin
        if (rst_in) begin
          data_ff <= `PCPD_RST_DATA;
          oe_n_ff <= `PCPD_RST_OE_N;
          keep_ff <= `PCPD_RST_DATA;
          fb_ff   <= `PCPD_RST_DATA;
        end else begin
          data_ff <= nxt_data;
          oe_n_ff <= nxt_oe_n;
          keep_ff <= nxt_keep;
          fb_ff   <= nxt_fb;
        end
      end

      assign data_q[g] = data_ff;
      assign oe_n_q[g] = oe_n_ff;
      assign keep_q[g] = keep_ff;
      assign fb_q[g]   = fb_ff;
    end
  endgenerate

  // ************************************************************
  // outputs
  // ************************************************************
  assign pin_data_out  = data_q;
  assign pin_oe_n_out  = oe_n_q;
  // keeper levels stay driven in hold so no pin floats
  assign pin_keep_out  = keep_q;
  assign feedback_out  = fb_q;
  assign hold_out      = hold;
  assign wake_busy_out = (state_ff == ST_WAKE);

endmodule // pcpd_power_down

// >>> rtl/pcpd_defines.vh
// pcpd_defines.vh: constants for the pin-controlled power-down block
// assumes inclusion by bare name from the rtl/ modules; definitions only
//
// Functional notes
// - optional sleep function; when enabled its pin is only a sleep request
// - sleep enabled and pin high means hold state; low means normal operation
// - entering hold freezes every output and internal state, outputs stay valid
// - outputs high-impedance at hold onset stay high-impedance throughout hold
// - during hold all inputs, clocks and enables are ignored except sleep pin
// - pin hold latches stay active in hold so no pin floats
// - sleep function enabled only by a build-time option, never a register
// - sleep pin not routed to logic array; its macrocell feedback stays usable
// - after sleep pin falls, inputs, enables and clocks accepted within 1 us
// - after sleep pin falls, valid updated outputs appear within 1 us
`ifndef PCPD_DEFINES_VH
`define PCPD_DEFINES_VH

// ************************************************************
// timing
// ************************************************************
`define PCPD_CLK_PERIOD_PS   5000
`define PCPD_WAKE_TIME_NS    1000
// longest time rounds down
`define PCPD_WAKE_CYCLES     ((`PCPD_WAKE_TIME_NS * 1000) / `PCPD_CLK_PERIOD_PS)
`define PCPD_CNT_W           8

// ************************************************************
// reset values
// ************************************************************
`define PCPD_RST_DATA        1'b0
`define PCPD_RST_OE_N        1'b1

`endif

// >>> rtl/pcpd_sync.v
// pcpd_sync.v: three-stage synchroniser with agreement filter
// assumes one clock; input arrives from a pin
`timescale 1ns/1ps
module pcpd_sync (
  input  wire mclk_in,
  input  wire rst_in,
  input  wire async_in,
  output wire level_out
);
  reg meta_ff;
  reg s2_ff;
  reg s3_ff;
  reg level_ff;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      meta_ff  <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
      // change counts only once stages two and three agree
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level_out = level_ff;
endmodule // pcpd_sync

// >>> tb/pcpd_power_down_properties.sv
// pcpd_power_down_properties.sv: port timing checks for the power-down block
// assumes bind onto pcpd_power_down, one clock, sync active-high reset
`timescale 1ns/1ps
module pcpd_chk #(parameter WIDTH = 8, parameter SLEEP_EN = 1) (
  input wire             mclk_in,
  input wire             rst_in,
  input wire             sleep_request_pin_in,
  input wire [WIDTH-1:0] pin_data_out,
  input wire [WIDTH-1:0] pin_oe_n_out,
  input wire [WIDTH-1:0] pin_keep_out,
  input wire [WIDTH-1:0] feedback_out,
  input wire             sleep_pin_as_io_out,
  input wire             hold_out,
  input wire             wake_busy_out
);
  // ************************************************************
  // hold entry, freeze, wake, reset release and sleep pin use
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // generous: covers the full 1 us ramp even at default size
  localparam int WAKE_MAX = 300;
  // six samples outlast the synchroniser and agreement stage
  sequence s_asleep; sleep_request_pin_in [*6]; endsequence
  sequence s_awake; !sleep_request_pin_in [*6]; endsequence
  chk_hold_enter: assert property (s_asleep |-> hold_out) else $error("hold not entered");
  chk_hold_leave: assert property (s_awake |-> !hold_out) else $error("hold not left");
  chk_data_frozen: assert property (hold_out |=> $stable(pin_data_out)) else $error("data moved");
  chk_hiz_kept: assert property (hold_out |=> $stable(pin_oe_n_out)) else $error("enable moved");
  chk_keeper_held: assert property (hold_out |=> $stable(pin_keep_out)) else $error("keeper moved");
  chk_input_blocked: assert property (hold_out |=> $stable(feedback_out)) else $error("feedback moved");
  chk_wake_start: assert property ($fell(hold_out) |-> ##[0:1] wake_busy_out) else $error("no ramp");
  chk_wake_bound: assert property ($rose(wake_busy_out) |-> ##[1:WAKE_MAX] !wake_busy_out)
    else $error("ramp too long");
  chk_reset_release: assert property ($fell(rst_in) |-> (&pin_oe_n_out) [*6]) else $error("pin driven");
  chk_pin_dedicated: assert property (sleep_pin_as_io_out == (SLEEP_EN == 0))
    else $error("sleep pin leaks");
endmodule // pcpd_chk

bind pcpd_power_down pcpd_chk #(.WIDTH(WIDTH), .SLEEP_EN(SLEEP_EN)) u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .sleep_request_pin_in(sleep_request_pin_in), .pin_data_out(pin_data_out), .pin_oe_n_out(pin_oe_n_out),
  .pin_keep_out(pin_keep_out), .feedback_out(feedback_out), .sleep_pin_as_io_out(sleep_pin_as_io_out),
  .hold_out(hold_out), .wake_busy_out(wake_busy_out));

// >>> tb/pcpd_ext_model.sv
// pcpd_ext_model.sv: outside system logic driving sleep and user pins
// assumes the bench calls its tasks; pins change 1 ns after a rising edge
`timescale 1ns/1ps
module pcpd_ext_model #(parameter WIDTH = 8) (
  input  wire             mclk_in,
  output reg              sleep_request_pin_out = 1'b0,
  output reg  [WIDTH-1:0] pin_data_out          = {WIDTH{1'b0}},
  output reg  [WIDTH-1:0] pin_oe_n_out          = {WIDTH{1'b1}},
  output reg              pin_load_out          = 1'b0,
  output reg              feedback_sel_out      = 1'b0
);
  // ************************************************************
  // pin driving
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic put(input [WIDTH-1:0] d, input [WIDTH-1:0] oe, input ld, input sel);
    pin_data_out = d;
    pin_oe_n_out = oe;
    pin_load_out = ld;
    feedback_sel_out = sel;
  endtask
  // pins were settled well before the edge; held long after raising it
  task automatic sleep(input s);
    tick(6);
    sleep_request_pin_out = s;
    if (s) tick(8);
  endtask
endmodule // pcpd_ext_model

// >>> tb/tb.sv
// tb.sv: self-checking bench for pcpd_power_down
// assumes the external model drives the sleep and user pins; the bench drives clock and reset
`timescale 1ns/1ps
module tb;
  localparam W = 8;
  localparam WAKE = 4;
  reg          mclk_in = 1'b0;
  reg          rst_in = 1'b1;
  wire         sl, ld, sel, io, hold, busy;
  wire [W-1:0] d, oe, q, qoe, keep, fb;
  integer      bad_count = 0;
  integer      tests_run = 0;
  integer      i, k;
  reg  [W-1:0] dv, ov, qe;
  reg  [31:0]  rnd;
  reg          lr;
  // ************************************************************
  // harness
  // ************************************************************
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  pcpd_ext_model #(.WIDTH(W)) px (.mclk_in(mclk_in), .sleep_request_pin_out(sl), .pin_data_out(d),
    .pin_oe_n_out(oe), .pin_load_out(ld), .feedback_sel_out(sel));
  pcpd_power_down #(.WIDTH(W), .SLEEP_EN(1), .WAKE_CYCLES(WAKE)) uut (.mclk_in(mclk_in), .rst_in(rst_in),
    .sleep_request_pin_in(sl), .pin_data_in(d), .pin_oe_n_in(oe), .pin_load_in(ld), .feedback_sel_in(sel),
    .pin_data_out(q), .pin_oe_n_out(qoe), .pin_keep_out(keep), .feedback_out(fb),
    .sleep_pin_as_io_out(io), .hold_out(hold), .wake_busy_out(busy));
  // buried feedback is the held data, true or inverted by the select
  function [W-1:0] fb_exp(input [W-1:0] v, input s);
    fb_exp = s ? v : ~v;
  endfunction
  task check(input [W-1:0] seen, input [W-1:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded poll so a stuck hold cannot hang the run
  task wait_hold(input want);
    for (k = 0; hold !== want && k < 20; k = k + 1) px.tick(1);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    #50000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    k = $urandom(39);
    px.tick(2);
    rst_in = 1'b0;
    px.tick(5);
    check(q, 8'h00);
    check(qoe, 8'hff);
    check({5'h00, io, hold, busy}, 8'h00);
    qe = 8'h00;
    // random data, enables, load and select; the first pass always loads
    for (i = 0; i < 6; i = i + 1) begin
      dv = $urandom;
      ov = (i == 0) ? 8'hff : $urandom;
      rnd = $urandom;
      lr = (i == 0) ? 1'b1 : rnd[0];
      px.put(dv, ov, lr, rnd[1]);
      px.tick(8);
      if (lr) qe = dv;
      check(q, qe);
      check(qoe, ov);
      check(keep, dv);
      check(fb, fb_exp(qe, rnd[1]));
      px.put(dv, ov, lr, ~rnd[1]);
      px.tick(8);
      check(fb, fb_exp(qe, ~rnd[1]));
      px.sleep(1'b1);
      check({7'h00, hold}, 8'h01);
      px.put(~dv, ~ov, rnd[2], rnd[3]);
      px.tick(10);
      check(q, qe);
      check(qoe, ov);
      check(keep, dv);
      check(fb, fb_exp(qe, ~rnd[1]));
      px.sleep(1'b0);
      wait_hold(1'b0);
      check({7'h00, hold}, 8'h00);
      check({7'h00, busy}, 8'h01);
      check(q, qe);
      px.tick(8);
      if (rnd[2]) qe = ~dv;
      check(q, qe);
      check(qoe, ~ov);
      check(keep, ~dv);
      check(fb, fb_exp(qe, rnd[3]));
      for (k = 0; busy !== 1'b0 && k < WAKE + 8; k = k + 1) px.tick(1);
      check({7'h00, busy}, 8'h00);
    end
    print_verdict;
  end
endmodule // tb
